// [rtl/can_io_output_default_cmds.sv]
// command handler for stored power-on and safe output values
`timescale 1ns/100ps
`default_nettype none
`include "can_io_consts.svh"
module can_io_output_default_cmds
#(
  parameter logic [55:0] MODULE_NAME = 56'h49_4f_4d_4f_44_30_31  // arbitrary
)
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        nv_erase_n_i,
  input  wire logic [7:0]  node_id_i,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic        req_ack_bit_i,
  input  wire logic [7:0]  req_func_i,
  input  wire logic [7:0]  req_node_i,
  input  wire logic [7:0]  req_adv_i,
  input  wire logic        req_rtr_i,
  input  wire logic [3:0]  req_dlc_i,
  input  wire logic [63:0] req_data_i,
  output logic             rsp_valid_o,
  output logic             rsp_ack_bit_o,
  output logic [7:0]       rsp_func_o,
  output logic [7:0]       rsp_node_o,
  output logic [7:0]       rsp_adv_o,
  output logic             rsp_rtr_o,
  output logic [3:0]       rsp_dlc_o,
  output logic [63:0]      rsp_data_o,
  input  wire logic        out_cmd_valid_i,
  input  wire logic [7:0]  out_cmd_value_i,
  input  wire logic        stall_i,
  input  wire logic        heartbeat_lost_i,
  output logic [7:0]       digital_output_o,
  output logic [7:0]       analog_output_channels_o
);
  import can_io_pkg::*;

  function automatic cmd_kind_t decode_cmd(input logic [7:0] func, input logic [7:0] adv,
                                           input logic rtr, input logic [3:0] dlc);
    cmd_kind_t kind;
    kind = CMD_NONE;
    if (func == `FUNC_PON && adv == `ADV_VALUE && dlc == `DLC_VALUE)
    begin
      kind = CMD_PON;
    end
    else if (func == `FUNC_SAFE && adv == `ADV_VALUE && dlc == `DLC_VALUE)
    begin
      kind = CMD_SAFE;
    end
    else if (func == `FUNC_NAME && adv == `ADV_NAME && rtr && dlc == `DLC_NAME)
    begin
      kind = CMD_NAME;
    end
    return kind;
  endfunction

  logic [1:0]  rst_sync;
  logic        rst_n;
  nv_if        nv ();

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  nv_default_store u_store
  (
    .clk_i     (clk_i),
    .erase_n_i (nv_erase_n_i),
    .nv        (nv.store)
  );

  boot_state_t state;
  boot_state_t next_state;
  logic [7:0]  pon_applied;
  logic [7:0]  next_pon_applied;
  logic        cmd_seen;
  logic        next_cmd_seen;
  logic [7:0]  cmd_value;
  logic [7:0]  next_cmd_value;
  logic [7:0]  next_digital;
  logic [7:0]  next_analog;
  logic        fault;
  logic        take;
  cmd_kind_t   kind;
  logic        next_rsp_valid;
  logic [3:0]  next_rsp_dlc;
  logic [63:0] next_rsp_data;
  logic [7:0]  next_rsp_func;
  logic [7:0]  next_rsp_adv;

  assign req_ready_o = (state == ST_RUN);
  assign take        = req_valid_i && req_ready_o && !req_ack_bit_i
                       && req_node_i == node_id_i;
  assign kind        = decode_cmd(req_func_i, req_adv_i, req_rtr_i, req_dlc_i);
  assign fault       = stall_i || heartbeat_lost_i;

  // boot: one cycle for the store read register, then latch the power-on value
  always_comb
  begin
    next_state       = state;
    next_pon_applied = pon_applied;
    next_cmd_seen    = cmd_seen;
    next_cmd_value   = cmd_value;
    case (state)
      ST_BOOT:
      begin
        next_state = ST_LOAD;
      end
      ST_LOAD:
      begin
        next_pon_applied = nv.pon;
        next_state       = ST_RUN;
      end
      ST_RUN:
      begin
        if (out_cmd_valid_i)
        begin
          next_cmd_seen  = 1'b1;
          next_cmd_value = out_cmd_value_i;
        end
      end
      default:
      begin
        next_state = ST_BOOT;
      end
    endcase
    next_analog  = cmd_seen ? cmd_value : pon_applied;
    next_digital = cmd_seen ? cmd_value : pon_applied;
    if (fault && state == ST_RUN)
    begin
      next_digital = nv.safe;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                    <= ST_BOOT;
      pon_applied              <= `PON_RESET;
      cmd_seen                 <= 1'b0;
      cmd_value                <= 8'h00;
      digital_output_o         <= `PON_RESET;
      analog_output_channels_o <= `PON_RESET;
    end
    else
    begin
      state                    <= next_state;
      pon_applied              <= next_pon_applied;
      cmd_seen                 <= next_cmd_seen;
      cmd_value                <= next_cmd_value;
      digital_output_o         <= next_digital;
      analog_output_channels_o <= next_analog;
    end
  end

  // command decode, store write and answer frame
  always_comb
  begin
    nv.wr_en       = 1'b0;
    nv.wr_addr     = `NV_ADDR_PON;
    nv.wr_data     = req_data_i[7:0];
    next_rsp_valid = 1'b0;
    next_rsp_dlc   = `DLC_VALUE;
    next_rsp_data  = 64'h0;
    next_rsp_func  = req_func_i;
    next_rsp_adv   = req_adv_i;
    if (take)
    begin
      case (kind)
        CMD_PON:
        begin
          next_rsp_valid = 1'b1;
          nv.wr_en       = !req_rtr_i;
          next_rsp_data  = {56'h0, req_rtr_i ? nv.pon : req_data_i[7:0]};
        end
        CMD_SAFE:
        begin
          next_rsp_valid = 1'b1;
          nv.wr_en       = !req_rtr_i;
          nv.wr_addr     = `NV_ADDR_SAFE;
          next_rsp_data  = {56'h0, req_rtr_i ? nv.safe : req_data_i[7:0]};
        end
        CMD_NAME:
        begin
          next_rsp_valid = 1'b1;
          next_rsp_dlc   = `DLC_NAME;
          for (int i = 0; i < 7; i++)
          begin
            next_rsp_data[8*i +: 8] = MODULE_NAME[8*(6-i) +: 8];
          end
        end
        default:
        begin
          next_rsp_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_o   <= 1'b0;
      rsp_ack_bit_o <= 1'b1;
      rsp_func_o    <= 8'h00;
      rsp_node_o    <= 8'h00;
      rsp_adv_o     <= 8'h00;
      rsp_rtr_o     <= 1'b0;
      rsp_dlc_o     <= 4'h0;
      rsp_data_o    <= 64'h0;
    end
    else
    begin
      rsp_valid_o   <= next_rsp_valid;
      rsp_ack_bit_o <= 1'b1;
      rsp_rtr_o     <= 1'b0;
      if (next_rsp_valid)
      begin
        rsp_func_o <= next_rsp_func;
        rsp_node_o <= node_id_i;
        rsp_adv_o  <= next_rsp_adv;
        rsp_dlc_o  <= next_rsp_dlc;
        rsp_data_o <= next_rsp_data;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  property p_ignore_foreign;
    req_valid_i && req_node_i != node_id_i |=> !rsp_valid_o;
  endproperty
  a_ignore_foreign: assert property (p_ignore_foreign) else $error("foreign frame answered");

  property p_pon_out;
    state == ST_RUN && !cmd_seen && !fault ##1 !fault |-> digital_output_o == pon_applied
      && analog_output_channels_o == pon_applied;
  endproperty
  a_pon_out: assert property (p_pon_out) else $error("outputs not at power-on value");

  property p_pon_deferred;
    take && kind == CMD_PON && !req_rtr_i |=> $stable(pon_applied) [*2];
  endproperty
  a_pon_deferred: assert property (p_pon_deferred) else $error("power-on value applied early");

  property p_safe_now;
    take && kind == CMD_SAFE && !req_rtr_i ##1 fault
      |=> digital_output_o == $past(req_data_i[7:0], 2);
  endproperty
  a_safe_now: assert property (p_safe_now) else $error("new safe value not used at once");

  property p_safe_out;
    state == ST_RUN && fault |=> digital_output_o == $past(nv.safe);
  endproperty
  a_safe_out: assert property (p_safe_out) else $error("safe value not driven on fault");

  property p_name;
    take && kind == CMD_NAME |=> rsp_valid_o && rsp_dlc_o == 4'h7
      && rsp_data_o[7:0] == MODULE_NAME[55:48] && rsp_data_o[55:48] == MODULE_NAME[7:0];
  endproperty
  a_name: assert property (p_name) else $error("name answer wrong");

  property p_rsp_frame;
    rsp_valid_o |-> rsp_ack_bit_o && !rsp_rtr_o && rsp_node_o == $past(node_id_i);
  endproperty
  a_rsp_frame: assert property (p_rsp_frame) else $error("answer frame fields wrong");

  property p_pon_query;
    take && kind == CMD_PON && req_rtr_i |=> rsp_valid_o && rsp_dlc_o == 4'h1
      && rsp_func_o == 8'h60 && rsp_data_o[7:0] == $past(nv.pon);
  endproperty
  a_pon_query: assert property (p_pon_query) else $error("power-on query answer wrong");

  property p_safe_query;
    take && kind == CMD_SAFE && req_rtr_i |=> rsp_valid_o && rsp_func_o == 8'h61
      && rsp_data_o[7:0] == $past(nv.safe);
  endproperty
  a_safe_query: assert property (p_safe_query) else $error("safe query answer wrong");
endmodule
`default_nettype wire

// [pkg/can_io_consts.svh]
// constants for the output-default command handler
// Notes on behaviour
// - After boot and until the first output command, analog outputs, and digital outputs while no fault is present, show the stored power-on value.
// - A power-on value that was never written reads as zero on every channel.
// - Writing a power-on value stores it in nonvolatile memory and it takes effect only at the next boot.
// - The power-on value command is function 60h, advanced flag 01h, one data byte, length code 1 for set and query.
// - While the module stalls or the host heartbeat is missing, the digital outputs show the stored safe value.
// - A safe value that was never written reads as zero on every digital channel.
// - Writing a safe value stores it in nonvolatile memory and it is used at once.
// - The safe value command is function 61h, advanced flag 01h, one data byte, length code 1 for set and query.
// - The module name is answered as ASCII bytes, one character per data byte, first character in byte 0.
// - The name query is function F0h, advanced flag 00h, remote frame, length 7, answered by a data frame of length 7.
`ifndef CAN_IO_CONSTS_SVH
`define CAN_IO_CONSTS_SVH
`define FUNC_PON       8'h60
`define FUNC_SAFE      8'h61
`define FUNC_NAME      8'hf0
`define ADV_VALUE      8'h01
`define ADV_NAME       8'h00
`define DLC_VALUE      4'h1
`define DLC_NAME       4'h7
`define PON_RESET      8'h00
`define SAFE_RESET     8'h00
`define NV_ADDR_PON    1'b0
`define NV_ADDR_SAFE   1'b1
`endif

// [pkg/can_io_pkg.sv]
// types for the output-default command handler
package can_io_pkg;
  typedef enum logic [1:0]
  {
    ST_BOOT = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } boot_state_t;

  typedef enum logic [1:0]
  {
    CMD_NONE = 2'b00,
    CMD_PON  = 2'b01,
    CMD_SAFE = 2'b10,
    CMD_NAME = 2'b11
  } cmd_kind_t;
endpackage

// [pkg/nv_if.sv]
// nonvolatile store access between handler and storage
`timescale 1ns/100ps
`default_nettype none
interface nv_if;
  logic       wr_en;
  logic       wr_addr;
  logic [7:0] wr_data;
  logic [7:0] pon;
  logic [7:0] safe;
  modport handler (output wr_en, output wr_addr, output wr_data, input pon, input safe);
  modport store   (input wr_en, input wr_addr, input wr_data, output pon, output safe);
endinterface
`default_nettype wire

// [rtl/nv_default_store.sv]
// nonvolatile storage of the power-on and safe bytes
`timescale 1ns/100ps
`default_nettype none
`include "can_io_consts.svh"
module nv_default_store
(
  input  wire logic clk_i,
  input  wire logic erase_n_i,
  nv_if.store       nv
);
  logic [7:0] pon;
  logic [7:0] safe;
  logic [7:0] next_pon;
  logic [7:0] next_safe;

  always_comb
  begin
    next_pon  = pon;
    next_safe = safe;
    if (nv.wr_en && nv.wr_addr == `NV_ADDR_PON)
    begin
      next_pon = nv.wr_data;
    end
    if (nv.wr_en && nv.wr_addr == `NV_ADDR_SAFE)
    begin
      next_safe = nv.wr_data;
    end
  end

  // only the factory erase clears the contents, not the module reset
  always_ff @(posedge clk_i or negedge erase_n_i)
  begin
    if (!erase_n_i)
    begin
      pon  <= `PON_RESET;
      safe <= `SAFE_RESET;
    end
    else
    begin
      pon  <= next_pon;
      safe <= next_safe;
    end
  end

  assign nv.pon  = pon;
  assign nv.safe = safe;
endmodule
`default_nettype wire

// [tb/can_host_model.sv]
// bus master model that sends command frames and watches for the answer
`timescale 1ns/100ps
`default_nettype none
module can_host_model
(
  input  wire logic   clk_i,
  input  wire logic   rsp_valid_i,
  output logic        req_valid_o,
  output logic        req_ack_bit_o,
  output logic [7:0]  req_func_o,
  output logic [7:0]  req_node_o,
  output logic [7:0]  req_adv_o,
  output logic        req_rtr_o,
  output logic [3:0]  req_dlc_o,
  output logic [63:0] req_data_o
);
  initial
  begin
    {req_valid_o, req_ack_bit_o, req_rtr_o, req_dlc_o} = '0;
    {req_func_o, req_node_o, req_adv_o, req_data_o} = '0;
  end

  // one frame per call; fields are scrambled once the frame is gone
  task automatic send(input logic [7:0] func, input logic [7:0] adv, input logic rtr,
                      input logic [3:0] dlc, input logic [7:0] node, input logic ack,
                      input logic [63:0] data, output logic answered);
    @(posedge clk_i);
    req_valid_o   <= 1'b1;
    req_ack_bit_o <= ack;
    req_rtr_o     <= rtr;
    {req_func_o, req_adv_o, req_node_o, req_dlc_o, req_data_o} <= {func, adv, node, dlc, data};
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    {req_func_o, req_adv_o, req_node_o, req_dlc_o, req_data_o} <= ~{func, adv, node, dlc, data};
    // the answer stands for one cycle only, right after the taking edge
    #1;
    answered = rsp_valid_i;
  endtask
endmodule
`default_nettype wire

// [tb/can_io_output_default_cmds_tb_top.sv]
// self-checking bench for the output-default command handler
`timescale 1ns/100ps
`default_nettype none
`include "can_io_consts.svh"
module can_io_output_default_cmds_tb_top;
  localparam logic [55:0] NAME = 56'h4e_4f_44_45_5f_41_42;  // arbitrary
  localparam logic [7:0]  NODE = 8'h0a;
  logic        clk = 1'b0, arst_n = 1'b0, erase_n = 1'b0, stall = 1'b0, hb_lost = 1'b0;
  logic        out_cmd_valid = 1'b0;
  logic [7:0]  out_cmd_value = 8'h00;
  logic        req_valid, req_ready, req_ack_bit, req_rtr, rsp_valid, rsp_ack_bit, rsp_rtr;
  logic [7:0]  req_func, req_node, req_adv, rsp_func, rsp_node, rsp_adv, dig, ana;
  logic [3:0]  req_dlc, rsp_dlc;
  logic [63:0] req_data, rsp_data;
  logic [7:0]  v, s, p;
  int          err_count = 0, samples_checked = 0, seed = 88850;
  int          pon_nv, safe_nv, shown;

  always #10 clk = ~clk;

  can_io_output_default_cmds #(.MODULE_NAME(NAME)) dut
  (
    .clk_i(clk), .arst_n_i(arst_n), .nv_erase_n_i(erase_n), .node_id_i(NODE),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_ack_bit_i(req_ack_bit),
    .req_func_i(req_func), .req_node_i(req_node), .req_adv_i(req_adv), .req_rtr_i(req_rtr),
    .req_dlc_i(req_dlc), .req_data_i(req_data), .rsp_valid_o(rsp_valid),
    .rsp_ack_bit_o(rsp_ack_bit), .rsp_func_o(rsp_func), .rsp_node_o(rsp_node),
    .rsp_adv_o(rsp_adv), .rsp_rtr_o(rsp_rtr), .rsp_dlc_o(rsp_dlc), .rsp_data_o(rsp_data),
    .out_cmd_valid_i(out_cmd_valid), .out_cmd_value_i(out_cmd_value), .stall_i(stall),
    .heartbeat_lost_i(hb_lost), .digital_output_o(dig), .analog_output_channels_o(ana)
  );

  can_host_model host
  (
    .clk_i(clk), .rsp_valid_i(rsp_valid), .req_valid_o(req_valid),
    .req_ack_bit_o(req_ack_bit), .req_func_o(req_func), .req_node_o(req_node),
    .req_adv_o(req_adv), .req_rtr_o(req_rtr), .req_dlc_o(req_dlc), .req_data_o(req_data)
  );

  task automatic close_out();
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [55:0] name_bytes();
    logic [55:0] r;
    for (int i = 0; i < 7; i++)
      r[8*i +: 8] = NAME[55-8*i -: 8];
    return r;
  endfunction

  task automatic chk_out();
    repeat (2) @(posedge clk);
    #1;
    check("digital", 64'(dig), 64'((stall | hb_lost) ? safe_nv : shown));
    check("analog", 64'(ana), 64'(shown));
  endtask

  task automatic do_reset(input logic erase);
    int i;
    @(posedge clk);
    arst_n  <= 1'b0;
    erase_n <= ~erase;
    repeat (5) @(posedge clk);
    arst_n  <= 1'b1;
    erase_n <= 1'b1;
    if (erase)
    begin
      pon_nv  = 0;
      safe_nv = 0;
    end
    shown = pon_nv;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    check("ready", 64'(req_ready), 64'h1);
    chk_out();
  endtask

  task automatic xfer(input logic [7:0] func, input logic [7:0] adv, input logic rtr,
                      input logic [3:0] dlc, input logic [7:0] node, input logic ack,
                      input logic [63:0] data, input logic want, input logic [55:0] exp);
    logic        got;
    logic [55:0] m;
    host.send(func, adv, rtr, dlc, node, ack, data, got);
    m = (dlc == `DLC_NAME) ? ~56'h0 : 56'hff;
    check("answered", 64'(got), 64'(want));
    if (want)
    begin
      check("rsp_head", 64'({rsp_ack_bit, rsp_rtr, rsp_func, rsp_adv, rsp_node, rsp_dlc}),
            64'({1'b1, 1'b0, func, adv, NODE, dlc}));
      check("rsp_data", 64'(rsp_data[55:0] & m), 64'(exp & m));
    end
  endtask

  task automatic out_cmd(input logic [7:0] val, input logic flt_a, input logic flt_b);
    @(posedge clk);
    out_cmd_valid <= 1'b1;
    out_cmd_value <= val;
    stall         <= flt_a;
    hb_lost       <= flt_b;
    @(posedge clk);
    out_cmd_valid <= 1'b0;
    shown = val;
    chk_out();
  endtask

  initial
  begin
    do_reset(1'b1);
    xfer(`FUNC_PON, `ADV_VALUE, 1'b1, `DLC_VALUE, NODE, 1'b0, '0, 1'b1, 56'h0);
    xfer(`FUNC_SAFE, `ADV_VALUE, 1'b1, `DLC_VALUE, NODE, 1'b0, '0, 1'b1, 56'h0);
    v = 8'($random(seed)) | 8'h01;
    out_cmd(v, 1'b1, 1'b0);
    s = 8'($random(seed)) | 8'h80;
    safe_nv = s;
    xfer(`FUNC_SAFE, `ADV_VALUE, 1'b0, `DLC_VALUE, NODE, 1'b0, 64'(s), 1'b1, 56'(s));
    chk_out();
    @(posedge clk);
    stall   <= 1'b0;
    hb_lost <= 1'b1;
    chk_out();
    p = ~v;
    pon_nv = p;
    xfer(`FUNC_PON, `ADV_VALUE, 1'b0, `DLC_VALUE, NODE, 1'b0, 64'(p), 1'b1, 56'(p));
    @(posedge clk);
    hb_lost <= 1'b0;
    chk_out();
    xfer(`FUNC_PON, `ADV_VALUE, 1'b1, `DLC_VALUE, NODE, 1'b0, '0, 1'b1, 56'(p));
    for (int i = 0; i < 5; i++)
      xfer(i == 4 ? 8'h62 : `FUNC_SAFE, i == 3 ? 8'h00 : `ADV_VALUE, 1'b0,
           i == 2 ? 4'h2 : `DLC_VALUE, i == 0 ? NODE ^ 8'h01 : NODE, i == 1, 64'(~s),
           1'b0, '0);
    xfer(`FUNC_NAME, `ADV_NAME, 1'b0, `DLC_NAME, NODE, 1'b0, '0, 1'b0, '0);
    xfer(`FUNC_SAFE, `ADV_VALUE, 1'b1, `DLC_VALUE, NODE, 1'b0, '0, 1'b1, 56'(s));
    xfer(`FUNC_NAME, `ADV_NAME, 1'b1, `DLC_NAME, NODE, 1'b0, '0, 1'b1, name_bytes());
    do_reset(1'b0);
    xfer(`FUNC_SAFE, `ADV_VALUE, 1'b1, `DLC_VALUE, NODE, 1'b0, '0, 1'b1, 56'(s));
    repeat (8)
    begin
      v = 8'($random(seed));
      s = 8'($random(seed));
      out_cmd(v, s[0], s[1]);
    end
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
